/* File: rtl/tdx_pkg.sv */
// =====================================================================
// Shared constants and carriers
package tdx_pkg;

  // ===================================================================
  // Opcodes
  localparam logic [7:0] OP_IRQ_OFF    = 8'h8F;
  localparam logic [7:0] OP_IRQ_ON     = 8'h9F;
  localparam logic [7:0] OP_DIV_REG    = 8'h94;
  localparam logic [7:0] OP_DIV_IND    = 8'h95;
  localparam logic [7:0] OP_DIV_IMM    = 8'h96;
  localparam logic [7:0] OP_ENTER      = 8'h1F;
  localparam logic [3:0] OP_DBNZ_LOW   = 4'hA;

  // ===================================================================
  // Cycle counts per instruction
  localparam logic [4:0] CYC_IRQ       = 5'h04;
  localparam logic [4:0] CYC_DIV       = 5'h1A;
  localparam logic [4:0] CYC_DIV_ZERO  = 5'h0A;
  localparam logic [4:0] CYC_DBNZ      = 5'h08;
  localparam logic [4:0] CYC_ENTER     = 5'h0E;

  // ===================================================================
  // Flag bit positions and system mode bit
  localparam int FLAG_C       = 7;
  localparam int FLAG_Z       = 6;
  localparam int FLAG_S       = 5;
  localparam int FLAG_V       = 4;
  localparam int SYM_GLOBAL   = 0;

  // ===================================================================
  // Reset values and pointer step
  localparam logic [7:0]  RST_SYM   = 8'h00;
  localparam logic [7:0]  RST_FLAGS = 8'h00;
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [15:0] WORD_STEP = 16'h0002;

  // ===================================================================
  // Carriers
  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] data;
  } tdx_rf_wr_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  data;
  } tdx_mem_req_t;

endpackage

/* File: rtl/tdx_exec.sv */
// Function
// (RULE_01) Interrupt-off clears system mode bit, 4 cycles
// (RULE_02) Disabled: pending kept, no vectoring
// (RULE_03) Listed instructions leave flags unchanged
// (RULE_04) Unsigned 16/8 divide, quotient low, remainder high
// (RULE_05) Overflow on quotient over 255 or zero divisor
// (RULE_06) Carry when overflow and quotient 256..511
// (RULE_07) Zero on zero divisor/quotient; sign is quotient msb
// (RULE_08) Divide takes 10 cycles on zero, else 26
// (RULE_09) Decrement register, branch when result nonzero
// (RULE_10) Signed byte added to next-byte address
// (RULE_11) Two bytes, register in upper nibble, 8 cycles
// (RULE_12) Software keeps loop counter in C0..CF
// (RULE_13) Interrupt-on sets system mode bit, 4 cycles
// (RULE_14) Pending requests serviced after interrupt-on
// (RULE_15) Enter pushes pointer, loads PC, 14 cycles
// (RULE_16) Exit pops pointer, loads PC, adds two
// (RULE_17) Software disables interrupts before editing masks
// (RULE_18) Exit adds two to stack pointer
// (RULE_19) Program words are high byte first
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module tdx_exec #(
  parameter logic [4:0] CYC_EXIT = 5'h0E
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  // Instruction issue
  input  wire logic                  issue,
  input  wire logic [7:0]            opcode,
  input  wire logic [7:0]            operand,
  input  wire logic [15:0]           next_pc,
  input  wire logic [7:0]            work_base,
  input  wire logic [7:0]            dst_addr,
  input  wire logic [15:0]           dst_pair,
  input  wire logic [7:0]            src_val,
  input  wire logic [7:0]            counter_val,
  input  wire logic [7:0]            flags_in,
  output logic                       busy,
  output logic                       done,
  // Interrupt handshake
  input  wire logic                  irq_pending,
  output logic                       vector_req,
  output logic [7:0]                 system_mode_reg,
  // Core state
  output logic [7:0]                 flags_reg,
  output logic [15:0]                pc_reg,
  output logic [15:0]                thread_pointer,
  output logic [15:0]                sp_reg,
  // Register file, stack memory, program memory
  output tdx_pkg::tdx_rf_wr_t        rf_wr,
  output tdx_pkg::tdx_mem_req_t      mem_req,
  input  wire logic [7:0]            mem_rdata,
  output logic                       pm_req,
  output logic [15:0]                pm_addr,
  input  wire logic [7:0]            pm_rdata
);

  // ===================================================================
  // Decode
  typedef enum logic [2:0] {
    K_NONE,
    K_IRQ_OFF,
    K_IRQ_ON,
    K_DIV,
    K_DBNZ,
    K_ENTER,
    K_EXIT
  } tdx_kind_t;

  typedef enum {
    ST_IDLE,
    ST_RUN
  } tdx_state_t;

  localparam logic [7:0] OP_EXIT = 8'h2F;

  function automatic tdx_kind_t decode(input logic [7:0] op);
    if (op == tdx_pkg::OP_IRQ_OFF)
      decode = K_IRQ_OFF;
    else if (op == tdx_pkg::OP_IRQ_ON)
      decode = K_IRQ_ON;
    else if (op == tdx_pkg::OP_DIV_REG || op == tdx_pkg::OP_DIV_IND || op == tdx_pkg::OP_DIV_IMM)
      decode = K_DIV;
    else if (op[3:0] == tdx_pkg::OP_DBNZ_LOW)
      decode = K_DBNZ;
    else if (op == tdx_pkg::OP_ENTER)
      decode = K_ENTER;
    else if (op == OP_EXIT)
      decode = K_EXIT;
    else
      decode = K_NONE;
  endfunction

  tdx_state_t  state_reg;
  tdx_kind_t   kind_reg;
  tdx_kind_t   kind_next;
  logic [4:0]  cnt_reg;
  logic [4:0]  len_reg;
  logic [4:0]  len_next;
  logic        take;
  logic        last;
  logic [7:0]  cnt_addr_reg;
  logic [7:0]  dec_val;
  logic [7:0]  dst_addr_reg;
  logic [15:0] dividend_reg;
  logic [8:0]  rem_reg;
  logic [15:0] quot_reg;
  logic [7:0]  divisor_reg;
  logic        div_zero_reg;
  logic [8:0]  rem_shift;
  logic        rem_fit;
  logic [7:0]  hi_byte_reg;

  assign kind_next = decode(opcode);
  assign take      = ce && issue && state_reg == ST_IDLE && kind_next != K_NONE;
  assign last      = state_reg == ST_RUN && cnt_reg == len_reg - 5'h01;
  assign dec_val   = counter_val - 8'h01;
  assign rem_shift = {rem_reg[7:0], dividend_reg[15]};
  assign rem_fit   = rem_shift >= {1'b0, divisor_reg};

  always_comb
  begin
    unique case (kind_next)
      K_IRQ_OFF: len_next = tdx_pkg::CYC_IRQ;                             // see (RULE_01)
      K_IRQ_ON:  len_next = tdx_pkg::CYC_IRQ;                             // see (RULE_13)
      K_DIV:     len_next = (src_val == 8'h00) ? tdx_pkg::CYC_DIV_ZERO
                                               : tdx_pkg::CYC_DIV;       // see (RULE_08)
      K_DBNZ:    len_next = tdx_pkg::CYC_DBNZ;                            // see (RULE_11)
      K_ENTER:   len_next = tdx_pkg::CYC_ENTER;                           // see (RULE_15)
      K_EXIT:    len_next = CYC_EXIT;
      default:   len_next = tdx_pkg::CYC_IRQ;
    endcase
  end

  // ===================================================================
  // Sequencer
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      kind_reg  <= K_NONE;
      cnt_reg   <= 5'h00;
      len_reg   <= 5'h00;
      busy      <= 1'b0;
      done      <= 1'b0;
    end
    else if (ce)
    begin
      done <= 1'b0;
      unique case (state_reg)
        ST_IDLE:
        begin
          if (take)
          begin
            state_reg <= ST_RUN;
            kind_reg  <= kind_next;
            len_reg   <= len_next;
            cnt_reg   <= 5'h01;
            busy      <= 1'b1;
          end
        end
        ST_RUN:
        begin
          cnt_reg <= cnt_reg + 5'h01;
          if (last)
          begin
            state_reg <= ST_IDLE;
            busy      <= 1'b0;
            done      <= 1'b1;
          end
        end
      endcase
    end
  end

  // ===================================================================
  // Global interrupt enable and vectoring
  always_ff @(posedge clk)
  begin
    if (rst)
      system_mode_reg <= tdx_pkg::RST_SYM;
    else if (ce && last && kind_reg == K_IRQ_OFF)
      system_mode_reg[tdx_pkg::SYM_GLOBAL] <= 1'b0;                      // see (RULE_01)
    else if (ce && last && kind_reg == K_IRQ_ON)
      system_mode_reg[tdx_pkg::SYM_GLOBAL] <= 1'b1;                      // see (RULE_13)
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      vector_req <= 1'b0;
    else if (ce)
      vector_req <= irq_pending && system_mode_reg[tdx_pkg::SYM_GLOBAL]
                    && state_reg == ST_IDLE && !issue;                    // see (RULE_02) see (RULE_14)
  end

  // ===================================================================
  // Divider
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dividend_reg <= tdx_pkg::RST_WORD;
      rem_reg      <= 9'h000;
      quot_reg     <= tdx_pkg::RST_WORD;
      divisor_reg  <= 8'h00;
      div_zero_reg <= 1'b0;
      dst_addr_reg <= 8'h00;
    end
    else if (ce)
    begin
      if (take)
      begin
        dividend_reg <= dst_pair;                                         // see (RULE_04)
        divisor_reg  <= src_val;
        div_zero_reg <= src_val == 8'h00;
        rem_reg      <= 9'h000;
        quot_reg     <= tdx_pkg::RST_WORD;
        dst_addr_reg <= dst_addr;
      end
      else if (kind_reg == K_DIV && !div_zero_reg && cnt_reg >= 5'h01 && cnt_reg <= 5'h10)
      begin
        dividend_reg <= {dividend_reg[14:0], 1'b0};
        rem_reg      <= rem_fit ? rem_shift - {1'b0, divisor_reg} : rem_shift;
        quot_reg     <= {quot_reg[14:0], rem_fit};
      end
    end
  end

  // ===================================================================
  // Flags
  always_ff @(posedge clk)
  begin
    if (rst)
      flags_reg <= tdx_pkg::RST_FLAGS;
    else if (ce)
    begin
      if (take)
        flags_reg <= flags_in;                                            // see (RULE_03)
      else if (last && kind_reg == K_DIV)
      begin
        flags_reg[tdx_pkg::FLAG_V] <= div_zero_reg || quot_reg[15:8] != 8'h00;          // see (RULE_05)
        flags_reg[tdx_pkg::FLAG_C] <= !div_zero_reg && quot_reg[15:9] == 7'h00
                                      && quot_reg[8];                                   // see (RULE_06)
        flags_reg[tdx_pkg::FLAG_Z] <= div_zero_reg || quot_reg == tdx_pkg::RST_WORD;    // see (RULE_07)
        flags_reg[tdx_pkg::FLAG_S] <= !div_zero_reg && quot_reg[7];                     // see (RULE_07)
      end
    end
  end

  // ===================================================================
  // Register file writes
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rf_wr        <= '0;
      cnt_addr_reg <= 8'h00;
    end
    else if (ce)
    begin
      rf_wr.we <= 1'b0;
      if (take && kind_next == K_DBNZ)
        cnt_addr_reg <= work_base | {4'h0, opcode[7:4]};                  // see (RULE_11)
      if (state_reg == ST_RUN && kind_reg == K_DBNZ && cnt_reg == 5'h01)
      begin
        rf_wr.we   <= 1'b1;
        rf_wr.addr <= cnt_addr_reg;
        rf_wr.data <= dec_val;                                            // see (RULE_09)
      end
      else if (state_reg == ST_RUN && kind_reg == K_DIV && !div_zero_reg && cnt_reg == 5'h11)
      begin
        rf_wr.we   <= 1'b1;
        rf_wr.addr <= dst_addr_reg | 8'h01;
        rf_wr.data <= quot_reg[7:0];                                      // see (RULE_04)
      end
      else if (state_reg == ST_RUN && kind_reg == K_DIV && !div_zero_reg && cnt_reg == 5'h12)
      begin
        rf_wr.we   <= 1'b1;
        rf_wr.addr <= dst_addr_reg & 8'hFE;
        rf_wr.data <= rem_reg[7:0];                                       // see (RULE_04)
      end
    end
  end

  // ===================================================================
  // Program counter, thread pointer, stack pointer and memory ports
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pc_reg         <= tdx_pkg::RST_WORD;
      thread_pointer <= tdx_pkg::RST_WORD;
      sp_reg         <= tdx_pkg::RST_WORD;
      mem_req        <= '0;
      pm_req         <= 1'b0;
      pm_addr        <= tdx_pkg::RST_WORD;
      hi_byte_reg    <= 8'h00;
    end
    else if (ce)
    begin
      mem_req.req <= 1'b0;
      mem_req.we  <= 1'b0;
      pm_req      <= 1'b0;
      if (take)
      begin
        pc_reg <= next_pc;
        if (kind_next == K_DBNZ && dec_val != 8'h00)
          pc_reg <= next_pc + {{8{operand[7]}}, operand};                 // see (RULE_09) see (RULE_10)
      end
      else if (state_reg == ST_RUN && kind_reg == K_ENTER)
      begin
        unique case (cnt_reg)
          5'h01:
          begin
            sp_reg       <= sp_reg - tdx_pkg::WORD_STEP;                  // see (RULE_15)
            mem_req.req  <= 1'b1;
            mem_req.we   <= 1'b1;
            mem_req.addr <= sp_reg - tdx_pkg::WORD_STEP;
            mem_req.data <= thread_pointer[15:8];
          end
          5'h02:
          begin
            mem_req.req    <= 1'b1;
            mem_req.we     <= 1'b1;
            mem_req.addr   <= sp_reg + 16'h0001;
            mem_req.data   <= thread_pointer[7:0];
            thread_pointer <= pc_reg;                                     // see (RULE_15)
          end
          5'h03:
          begin
            pm_req  <= 1'b1;
            pm_addr <= thread_pointer;
          end
          5'h04:
          begin
            pm_req  <= 1'b1;
            pm_addr <= thread_pointer + 16'h0001;
          end
          5'h05:
            hi_byte_reg <= pm_rdata;                                      // see (RULE_19)
          5'h06:
          begin
            pc_reg         <= {hi_byte_reg, pm_rdata};                    // see (RULE_19)
            thread_pointer <= thread_pointer + tdx_pkg::WORD_STEP;        // see (RULE_15)
          end
          default:
          begin
          end
        endcase
      end
      else if (state_reg == ST_RUN && kind_reg == K_EXIT)
      begin
        unique case (cnt_reg)
          5'h01:
          begin
            mem_req.req  <= 1'b1;
            mem_req.addr <= sp_reg;
          end
          5'h02:
          begin
            mem_req.req  <= 1'b1;
            mem_req.addr <= sp_reg + 16'h0001;
          end
          5'h03:
            hi_byte_reg <= mem_rdata;
          5'h04:
          begin
            thread_pointer <= {hi_byte_reg, mem_rdata};                   // see (RULE_16)
            sp_reg         <= sp_reg + tdx_pkg::WORD_STEP;                // see (RULE_18)
          end
          5'h05:
          begin
            pm_req  <= 1'b1;
            pm_addr <= thread_pointer;
          end
          5'h06:
          begin
            pm_req  <= 1'b1;
            pm_addr <= thread_pointer + 16'h0001;
          end
          5'h07:
            hi_byte_reg <= pm_rdata;                                      // see (RULE_19)
          5'h08:
          begin
            pc_reg         <= {hi_byte_reg, pm_rdata};                    // see (RULE_16)
            thread_pointer <= thread_pointer + tdx_pkg::WORD_STEP;        // see (RULE_16)
          end
          default:
          begin
          end
        endcase
      end
    end
  end

endmodule // tdx_exec

`default_nettype wire

/* File: test/tdx_exec_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Checker
module tdx_exec_sva #(
  parameter logic [4:0] CYC_EXIT = 5'h0E
) (
  // Clock and issue
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        issue,
  input wire logic [7:0]  opcode,
  input wire logic [7:0]  src_val,
  input wire logic [7:0]  counter_val,
  input wire logic [7:0]  flags_in,
  input wire logic [15:0] next_pc,
  input wire logic        irq_pending,
  // Results
  input wire logic        busy,
  input wire logic        done,
  input wire logic        vector_req,
  input wire logic [7:0]  system_mode_reg,
  input wire logic [7:0]  flags_reg,
  input wire logic [15:0] pc_reg,
  input wire logic [15:0] sp_reg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic tk;
  logic dv;
  assign tk = ce && issue && !busy;
  assign dv = opcode inside {tdx_pkg::OP_DIV_REG, tdx_pkg::OP_DIV_IND, tdx_pkg::OP_DIV_IMM};
  sequence s_run3;
    busy[*3] ##1 (done && !busy);
  endsequence
  property p_off;
    tk && opcode == tdx_pkg::OP_IRQ_OFF |=> s_run3 ##0 !system_mode_reg[0];
  endproperty
  a_off: assert property (p_off) else $error("irq off wrong");
  property p_on;
    tk && opcode == tdx_pkg::OP_IRQ_ON |=> s_run3 ##0 system_mode_reg[0];
  endproperty
  a_on: assert property (p_on) else $error("irq on wrong");
  property p_novec;
    !system_mode_reg[0] |=> !vector_req;
  endproperty
  a_novec: assert property (p_novec) else $error("vector while off");
  property p_vec;
    ce && system_mode_reg[0] && irq_pending && !busy && !issue |=> vector_req;
  endproperty
  a_vec: assert property (p_vec) else $error("no vector");
  property p_dz;
    tk && dv && src_val == 8'h00 |=> busy[*8] ##1 busy ##1 (done && flags_reg[7:4] == 4'h5);
  endproperty
  a_dz: assert property (p_dz) else $error("zero divide wrong");
  property p_dlen;
    tk && dv && src_val != 8'h00 |-> ##25 (busy && !done) ##1 done;
  endproperty
  a_dlen: assert property (p_dlen) else $error("divide length");
  property p_dbz;
    tk && opcode[3:0] == 4'hA |=> busy[*7] ##1 done;
  endproperty
  a_dbz: assert property (p_dbz) else $error("loop length");
  property p_fall;
    tk && opcode[3:0] == 4'hA && counter_val == 8'h01 |=> pc_reg == $past(next_pc);
  endproperty
  a_fall: assert property (p_fall) else $error("loop exit pc");
  property p_flg;
    tk && (opcode inside {8'h8F, 8'h9F, 8'h1F, 8'h2F} || opcode[3:0] == 4'hA)
      |-> ##4 flags_reg == $past(flags_in, 4);
  endproperty
  a_flg: assert property (p_flg) else $error("flags changed");
  property p_ent;
    tk && opcode == tdx_pkg::OP_ENTER |-> ##14 done && sp_reg == $past(sp_reg, 14) - 16'h0002;
  endproperty
  a_ent: assert property (p_ent) else $error("enter wrong");
endmodule // tdx_exec_sva

bind tdx_exec tdx_exec_sva #(.CYC_EXIT(CYC_EXIT)) u_sva (.clk, .rst, .ce, .issue, .opcode, .src_val,
  .counter_val, .flags_in, .next_pc, .irq_pending, .busy, .done, .vector_req, .system_mode_reg,
  .flags_reg, .pc_reg, .sp_reg);
`default_nettype wire

/* File: test/tdx_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Stack and program memory
module tdx_mem_model (
  // Clock
  input wire logic                  clk,
  // Stack memory
  input wire tdx_pkg::tdx_mem_req_t mem_req,
  output logic [7:0]                mem_rdata,
  // Program memory
  input wire logic                  pm_req,
  input wire logic [15:0]           pm_addr,
  output logic [7:0]                pm_rdata
);
  logic [7:0] stk [256];
  initial mem_rdata = 8'hA5;
  initial pm_rdata = 8'h5A;
  // Data valid one cycle after request, inverted otherwise
  always @(posedge clk)
  begin
    if (mem_req.req && mem_req.we) stk[mem_req.addr[7:0]] <= mem_req.data;
    mem_rdata <= (mem_req.req && !mem_req.we) ? stk[mem_req.addr[7:0]] : ~mem_rdata;
    pm_rdata <= pm_req ? (pm_addr[7:0] ^ 8'h3C) : ~pm_rdata;
  end
endmodule // tdx_mem_model
`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ==========
  // Signals
  logic                  clk, rst, ce, issue, irq_pending, busy, done, vector_req, pm_req;
  logic [7:0]            opcode, operand, work_base, dst_addr, src_val, counter_val, flags_in;
  logic [7:0]            mem_rdata, pm_rdata, system_mode_reg, flags_reg;
  logic [15:0]           next_pc, dst_pair, pm_addr, pc_reg, thread_pointer, sp_reg;
  tdx_pkg::tdx_rf_wr_t   rf_wr;
  tdx_pkg::tdx_mem_req_t mem_req;
  logic [31:0]           rnd;
  logic [15:0]           m_pc, m_tp, m_sp;
  logic [63:0]           exp_q [$];
  logic [16:0]           wr_q [$];
  logic [15:0]           tp_q [$];
  logic [63:0]           e;
  logic [16:0]           w;
  int                    n_errors, num_checks;
  logic [15:0]           dvd [6] = '{16'h1003, 16'h1003, 16'h0200, 16'h0100, 16'h00FF, 16'h0005};
  logic [7:0]            dvs [6] = '{8'h40, 8'h00, 8'h01, 8'h01, 8'h01, 8'h10};

  tdx_exec uut (.clk, .rst, .ce, .issue, .opcode, .operand, .next_pc, .work_base, .dst_addr, .dst_pair,
    .src_val, .counter_val, .flags_in, .busy, .done, .irq_pending, .vector_req, .system_mode_reg,
    .flags_reg, .pc_reg, .thread_pointer, .sp_reg, .rf_wr, .mem_req, .mem_rdata, .pm_req, .pm_addr,
    .pm_rdata);
  tdx_mem_model u_mem (.clk, .mem_req, .mem_rdata, .pm_req, .pm_addr, .pm_rdata);

  // ==========
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] pw(input logic [15:0] a);
    return {a[7:0] ^ 8'h3C, (a[7:0] + 8'h01) ^ 8'h3C};
  endfunction
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    if (n_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========
  // Driver with expectations
  task automatic op(input logic [7:0] oc, input logic [7:0] od, input logic [15:0] dp,
                    input logic [7:0] sv, input logic [7:0] cv);
    logic [15:0] q, np;
    logic [7:0]  f, m;
    int          k;
    rnd = lfsr(rnd);
    np = rnd[15:0];
    f = rnd[31:24];
    m = 8'hFF;
    m_pc = np;
    if (oc inside {8'h94, 8'h95, 8'h96})
    begin
      q = (sv == 8'h00) ? 16'h0000 : dp / sv;
      f[7:4] = {sv != 0 && q[15:9] == 0 && q[8], sv == 0 || q == 0, sv != 0 && q[7], sv == 0 || q[15:8] != 0};
      if (sv != 0 && q[15:8] != 0) m = 8'hDF;
      if (sv != 0) wr_q.push_back({q[15:8] == 0, dst_addr | 8'h01, q[7:0]});
      if (sv != 0) wr_q.push_back({q[15:8] == 0, dst_addr & 8'hFE, 8'(dp % sv)});
    end
    else if (oc[3:0] == 4'hA)
    begin
      wr_q.push_back({1'b1, work_base | {4'h0, oc[7:4]}, cv - 8'h01});
      m_pc = (cv == 8'h01) ? np : np + {{8{od[7]}}, od};
    end
    else if (oc == tdx_pkg::OP_ENTER)
    begin
      tp_q.push_back(m_tp);
      m_sp = m_sp - 16'h0002;
      m_pc = pw(np);
      m_tp = np + 16'h0002;
    end
    else if (oc == 8'h2F)
    begin
      m_tp = tp_q.pop_back();
      m_sp = m_sp + 16'h0002;
      m_pc = pw(m_tp);
      m_tp = m_tp + 16'h0002;
    end
    exp_q.push_back({m, f, m_pc, m_tp, m_sp});
    @(posedge clk);
    opcode <= oc;
    operand <= od;
    next_pc <= np;
    dst_pair <= dp;
    src_val <= sv;
    counter_val <= cv;
    flags_in <= rnd[31:24];
    issue <= 1'b1;
    @(posedge clk);
    issue <= 1'b0;
    k = 0;
    do
    begin
      @(negedge clk);
      k++;
    end while (done !== 1'b1 && k < 40);
    if (done !== 1'b1)
    begin
      n_errors++;
      final_report();
    end
  endtask

  // ==========
  // Result monitor
  always @(negedge clk)
  begin
    if (!rst && rf_wr.we === 1'b1)
    begin
      w = wr_q.pop_front();
      check("rf_addr", rf_wr.addr, w[15:8]);
      if (w[16]) check("rf_data", rf_wr.data, w[7:0]);
    end
    if (!rst && done === 1'b1)
    begin
      e = exp_q.pop_front();
      check("flags", flags_reg & e[63:56], e[55:48] & e[63:56]);
      check("core_state", {pc_reg, thread_pointer, sp_reg}, e[47:0]);
    end
  end

  // ==========
  // Clock, watchdog, sequence
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    #25000;
    n_errors++;
    final_report();
  end
  initial
  begin
    rst = 1'b1; ce = 1'b1; issue = 1'b0; irq_pending = 1'b0; opcode = 8'h00; operand = 8'h00;
    next_pc = 16'h0000; dst_pair = 16'h0000; src_val = 8'h00; counter_val = 8'h00; flags_in = 8'h00;
    work_base = 8'hC0;
    dst_addr = 8'h20; rnd = 32'h4e65; m_pc = 16'h0000; m_tp = 16'h0000; m_sp = 16'h0000;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    irq_pending <= 1'b1;
    repeat (3) @(negedge clk);
    check("vec_off", vector_req, 1'b0);
    op(tdx_pkg::OP_IRQ_ON, 8'h00, 16'h0000, 8'h00, 8'h00);
    repeat (2) @(negedge clk);
    check("vec_on", vector_req, 1'b1);
    check("sym_on", system_mode_reg, 8'h01);
    op(tdx_pkg::OP_IRQ_OFF, 8'h00, 16'h0000, 8'h00, 8'h00);
    repeat (2) @(negedge clk);
    check("sym_off", {system_mode_reg, vector_req}, 9'h000);
    for (int i = 0; i < 14; i++)
    begin
      rnd = lfsr(rnd);
      op(8'h94 + 8'(i % 3), 8'h00, (i < 6) ? dvd[i] : rnd[15:0], (i < 6) ? dvs[i] : rnd[23:16], 8'h00);
    end
    op(8'h3A, 8'h7F, 16'h0000, 8'h00, 8'h01);
    op(8'h5A, 8'h7F, 16'h0000, 8'h00, 8'h02);
    op(8'hFA, 8'h80, 16'h0000, 8'h00, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      op({rnd[3:0], 4'hA}, rnd[15:8], 16'h0000, 8'h00, rnd[23:16]);
    end
    op(tdx_pkg::OP_ENTER, 8'h00, 16'h0000, 8'h00, 8'h00);
    op(tdx_pkg::OP_ENTER, 8'h00, 16'h0000, 8'h00, 8'h00);
    op(8'h2F, 8'h00, 16'h0000, 8'h00, 8'h00);
    op(8'h2F, 8'h00, 16'h0000, 8'h00, 8'h00);
    // Clock enable low freezes everything, even a pending issue
    @(posedge clk);
    ce <= 1'b0;
    opcode <= tdx_pkg::OP_IRQ_ON;
    issue <= 1'b1;
    repeat (4) @(posedge clk);
    ce <= 1'b1;
    issue <= 1'b0;
    @(negedge clk);
    check("ce_hold", {busy, system_mode_reg, pc_reg}, {1'b0, 8'h00, m_pc});
    repeat (4) @(negedge clk);
    check("queues_empty", exp_q.size() + wr_q.size(), 0);
    final_report();
  end
endmodule // tb
`default_nettype wire
